// ---- hw/fpe_controller.sv ----
/*
 * Flash program/erase sequencer: command port, state, page selector and
 * sector lock on APB; guards core byte programming and page/mass erase.
 * Assumes the flash array answers a read one cycle after fl.re and erases
 * or programs while the matching strobe's pulse is timed here.
 */
// Chosen here: the APB interface to the registers.
// Function
// - Erased bytes read FFh; programming only clears bits, erase restores ones.
// - Page-erase unlock opens one page; finished mass erase opens all memory.
// - Core stalls during byte programming; clock and peripherals keep running.
// - Any command write other than erase commands ends programming, relocks.
// - Page erase command on an active page erases it, stalling the core.
// - Page erase refused when its sector is locked.
// - Page erase completion releases the core and relocks.
// - Debugger mass erase clears everything, stalls core, then relocks.
// - Debugger access ignores write protect, sector locks and page limit.
// - Debug mode: lock bits writable, no page rewrite, mass erase enabled.
// - Unlock needs two consecutive command writes, first then second code.
// - Unknown or out-of-order command relocks.
// - One address: writes go to command port, reads show state.
// - After first code and sector code, next page write hits sector lock.
// - State code encoding as listed; top two bits read zero.
// - Page field gives address bits 15:9; absent upper bits held zero.
// - Page selector bit 7 maps information area to top 512 bytes.
// - Sector lock bits reset to zero and cannot be cleared by user code.
// - Only one page open at a time; new page needs new unlock.
// - Each lock bit guards one sector; absent sectors held zero.
// - Page rewritten after unlock must match, else relock.
// - Locked sector rejects core program and erase, not debugger.
`default_nettype none
module fpe_controller
   import fpe_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int PAGE_BITS = 7,
   parameter int NUM_SECTORS = 8,
   parameter int SECTOR_PAGE_SHIFT = 0,
   parameter int PROG_CYC = PROG_CYCLES,
   parameter int PERASE_CYC = PERASE_CYCLES,
   parameter int MERASE_CYC = MERASE_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic debug_access,
   input wire logic write_protect_option,
   input wire fpe_core_req_t core_req,
   output logic core_done,
   output logic core_refused,
   output logic cpu_stall,
   output logic info_map_en,
   output fpe_flash_t fl,
   input wire logic [7:0] fl_rdata
);
   typedef struct packed {
      fpe_state_t st;
      logic [2:0] sub;
      logic [7:0] page_sel;
      logic [7:0] sector_lock;
      logic mass_open;
      logic ret_active;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic core_done;
      logic core_refused;
      logic cpu_stall;
      logic tmr_start;
      logic [31:0] tmr_load;
      fpe_flash_t fl;
   } fpe_regs_t;

   fpe_regs_t r_reg, r_next;
   logic tmr_done;
   logic acc, wr_cmd, wr_page, rd_cmd, rd_page, dbg, wp_ok, prog_ok;
   logic [7:0] wbyte;

   initial begin
      if (ADDR_W < 14 || PAGE_BITS < 1 || PAGE_BITS > 7 || NUM_SECTORS < 1
          || NUM_SECTORS > 8 || PROG_CYC < 1 || PERASE_CYC < 1 || MERASE_CYC < 1) begin
         $error("fpe_controller: parameter out of range");
      end
   end

   // ***********************************
   // Helpers
   // ***********************************
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
      return a == ADDR_W'({idx, 2'b00});
   endfunction

   // Sector of a page, with sectors beyond the fitted memory treated as open
   function automatic logic sect_locked(input logic [6:0] page, input logic [7:0] lock);
      logic [6:0] s;
      s = page >> SECTOR_PAGE_SHIFT;
      return (s < 7'(NUM_SECTORS)) ? lock[s[2:0]] : 1'b0;
   endfunction

   function automatic logic [7:0] page_mask(input logic [7:0] v);
      return {v[INFO_EN_BIT], v[6:0] & 7'((1 << PAGE_BITS) - 1)};
   endfunction

   function automatic logic [5:0] stat_code(input fpe_regs_t r);
      logic [5:0] c;
      c = STAT_LOCKED;
      unique case (r.st)
         ST_LOCKED: c = STAT_LOCKED;
         ST_FIRST: c = STAT_FIRST;
         ST_SECOND: c = STAT_SECOND;
         ST_ACTIVE: c = STAT_UNLOCKED;
         ST_SECTSEL: c = STAT_SECTSEL;
         ST_PROG: c = {STAT_PROG, r.sub};
         ST_PERASE: c = {STAT_PERASE, r.sub};
         ST_MERASE: c = {STAT_MERASE, r.sub};
         default: c = STAT_LOCKED;
      endcase
      return c;
   endfunction

   fpe_op_timer #(.WIDTH(32)) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .start(r_reg.tmr_start),
      .load(r_reg.tmr_load),
      .done(tmr_done)
   );

   // ***********************************
   // Next state
   // ***********************************
   always_comb begin
      r_next = r_reg;
      acc = psel && penable && r_reg.pready;
      wr_cmd = acc && pwrite && hit(paddr, IDX_CMD);
      wr_page = acc && pwrite && hit(paddr, IDX_PAGE);
      rd_cmd = psel && penable && !r_reg.pready && !pwrite && hit(paddr, IDX_CMD);
      rd_page = psel && penable && !r_reg.pready && !pwrite && hit(paddr, IDX_PAGE);
      wbyte = pwdata[7:0];
      dbg = debug_access;
      wp_ok = write_protect_option;
      // Debugger ignores page limit, write protect and sector locks
      prog_ok = (core_req.dbg || (wp_ok && !sect_locked(core_req.addr[15:9],
                 r_reg.sector_lock)))
                && ((r_reg.st == ST_ACTIVE && (core_req.dbg
                     || core_req.addr[15:9] == r_reg.page_sel[6:0]))
                    || (r_reg.st == ST_LOCKED && r_reg.mass_open));
      r_next.pready = psel && penable && !r_reg.pready;
      r_next.pslverr = psel && penable && !r_reg.pready
                       && !hit(paddr, IDX_CMD) && !hit(paddr, IDX_PAGE);
      r_next.prdata = '0;
      if (rd_cmd) begin
         r_next.prdata = {24'h0, 2'b00, stat_code(r_reg)};
      end else if (rd_page) begin
         r_next.prdata = {24'h0, (r_reg.st == ST_SECTSEL) ? r_reg.sector_lock : r_reg.page_sel};
      end
      r_next.core_done = 1'b0;
      r_next.core_refused = 1'b0;
      r_next.tmr_start = 1'b0;
      r_next.fl.re = 1'b0;
      r_next.fl.we = 1'b0;
      r_next.fl.page_erase = 1'b0;
      r_next.fl.mass_erase = 1'b0;
      if (wr_cmd) begin
         r_next.mass_open = 1'b0;
      end
      unique case (r_reg.st)
         ST_LOCKED: begin
            if (wr_cmd) begin
               r_next.st = (wbyte == CMD_UNLOCK1) ? ST_FIRST : ST_LOCKED;
            end else if (wr_page) begin
               r_next.page_sel = page_mask(wbyte);
            end
         end
         ST_FIRST: begin
            if (wr_cmd) begin
               if (wbyte == CMD_UNLOCK2) begin
                  r_next.st = dbg ? ST_ACTIVE : ST_SECOND;
               end else if (wbyte == CMD_SECT_ACCESS) begin
                  r_next.st = ST_SECTSEL;
               end else begin
                  r_next.st = ST_LOCKED;
               end
            end else if (wr_page) begin
               r_next.page_sel = page_mask(wbyte);
            end
         end
         ST_SECOND: begin
            if (wr_cmd) begin
               r_next.st = ST_LOCKED;
            end else if (wr_page) begin
               // The rewrite guards against a stray page write opening a page
               r_next.st = (page_mask(wbyte) == r_reg.page_sel) ? ST_ACTIVE : ST_LOCKED;
            end
         end
         ST_SECTSEL: begin
            if (wr_cmd) begin
               r_next.st = ST_LOCKED;
            end else if (wr_page) begin
               // User code can only add protection; debugger may clear
               r_next.sector_lock = (dbg ? wbyte : (r_reg.sector_lock | wbyte))
                                    & 8'((1 << NUM_SECTORS) - 1);
               r_next.st = ST_LOCKED;
            end
         end
         ST_ACTIVE: begin
            if (wr_cmd) begin
               if (wbyte == CMD_PAGE_ERASE && (dbg || (wp_ok
                   && !sect_locked(r_reg.page_sel[6:0], r_reg.sector_lock)))) begin
                  r_next.st = ST_PERASE;
                  r_next.sub = 3'h0;
               end else if (wbyte == CMD_MASS_ERASE && dbg) begin
                  r_next.st = ST_MERASE;
                  r_next.sub = 3'h0;
               end else begin
                  r_next.st = ST_LOCKED;
               end
            end else if (wr_page && dbg) begin
               r_next.page_sel = page_mask(wbyte);
            end
         end
         ST_PROG: begin
            unique case (r_reg.sub)
               3'h0: r_next.sub = 3'h1;
               3'h1: begin
                  // Read-merge keeps bits already at zero; ones only via erase
                  r_next.fl.wdata = fl_rdata & r_reg.fl.wdata;
                  r_next.fl.we = 1'b1;
                  r_next.tmr_start = 1'b1;
                  r_next.tmr_load = 32'(PROG_CYC);
                  r_next.sub = 3'h2;
               end
               default: begin
                  if (tmr_done) begin
                     r_next.st = r_reg.ret_active ? ST_ACTIVE : ST_LOCKED;
                     r_next.cpu_stall = 1'b0;
                     r_next.core_done = 1'b1;
                  end
               end
            endcase
         end
         ST_PERASE, ST_MERASE: begin
            if (r_reg.sub == 3'h0) begin
               r_next.fl.page_erase = (r_reg.st == ST_PERASE);
               r_next.fl.mass_erase = (r_reg.st == ST_MERASE);
               r_next.fl.addr = (r_reg.st == ST_PERASE)
                                ? {r_reg.page_sel[6:0], 9'h000} : 16'h0000;
               r_next.tmr_start = 1'b1;
               r_next.tmr_load = (r_reg.st == ST_PERASE) ? 32'(PERASE_CYC) : 32'(MERASE_CYC);
               r_next.cpu_stall = 1'b1;
               r_next.sub = 3'h1;
            end else if (tmr_done) begin
               r_next.mass_open = (r_reg.st == ST_MERASE);
               r_next.st = ST_LOCKED;
               r_next.cpu_stall = 1'b0;
               r_next.sub = 3'h0;
            end
         end
         default: r_next.st = ST_LOCKED;
      endcase
      // Core byte program; in locked and active states refusals answer at once, other states hold the request
      if (core_req.valid && !r_reg.core_done && !r_reg.core_refused && !wr_cmd
          && (r_reg.st == ST_ACTIVE || r_reg.st == ST_LOCKED)) begin
         if (prog_ok) begin
            r_next.ret_active = (r_reg.st == ST_ACTIVE);
            r_next.st = ST_PROG;
            r_next.sub = 3'h0;
            r_next.cpu_stall = 1'b1;
            r_next.fl.re = 1'b1;
            r_next.fl.addr = core_req.addr;
            r_next.fl.wdata = core_req.data;
         end else begin
            r_next.core_refused = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata = r_reg.prdata;
   assign pready = r_reg.pready;
   assign pslverr = r_reg.pslverr;
   assign core_done = r_reg.core_done;
   assign core_refused = r_reg.core_refused;
   assign cpu_stall = r_reg.cpu_stall;
   assign info_map_en = r_reg.page_sel[INFO_EN_BIT];
   assign fl = r_reg.fl;

   // ***********************************
   // Checks
   // ***********************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_stall_prog;
      r_reg.st == ST_PROG && r_reg.sub != 3'h0 |-> cpu_stall;
   endproperty
   a_stall_prog: assert property (p_stall_prog) else $error("core not stalled");

   property p_merge;
      r_reg.st == ST_PROG && r_reg.sub == 3'h1 |=> fl.we && fl.wdata == ($past(fl_rdata)
         & $past(r_reg.fl.wdata));
   endproperty
   a_merge: assert property (p_merge) else $error("program set a bit");

   property p_unlock;
      r_reg.st == ST_LOCKED && wr_cmd && wbyte == CMD_UNLOCK1 |=> r_reg.st == ST_FIRST;
   endproperty
   a_unlock: assert property (p_unlock) else $error("first code not taken");

   property p_bad_cmd;
      wr_cmd && r_reg.st == ST_ACTIVE && wbyte != CMD_PAGE_ERASE
         && wbyte != CMD_MASS_ERASE |=> r_reg.st == ST_LOCKED;
   endproperty
   a_bad_cmd: assert property (p_bad_cmd) else $error("no relock");

   property p_seq;
      wr_cmd && r_reg.st == ST_SECOND |=> r_reg.st == ST_LOCKED;
   endproperty
   a_seq: assert property (p_seq) else $error("out of order kept");

   property p_prot;
      wr_cmd && r_reg.st == ST_ACTIVE && !dbg
         && sect_locked(r_reg.page_sel[6:0], r_reg.sector_lock) |=> r_reg.st != ST_PERASE;
   endproperty
   a_prot: assert property (p_prot) else $error("locked page erased");

   property p_sticky;
      r_reg.sector_lock != 8'h00 && !dbg |=> (r_reg.sector_lock & $past(r_reg.sector_lock))
         == $past(r_reg.sector_lock);
   endproperty
   a_sticky: assert property (p_sticky) else $error("lock bit cleared");

   property p_erase_end;
      r_reg.st == ST_PERASE && r_reg.sub == 3'h1 && tmr_done
         |=> r_reg.st == ST_LOCKED && !cpu_stall;
   endproperty
   a_erase_end: assert property (p_erase_end) else $error("erase end wrong");

   property p_mass;
      wr_cmd && r_reg.st == ST_ACTIVE && wbyte == CMD_MASS_ERASE && !dbg
         |=> r_reg.st == ST_LOCKED;
   endproperty
   a_mass: assert property (p_mass) else $error("user mass erase");

   property p_stat;
      pready && !pslverr && $past(rd_cmd) |-> prdata[31:6] == 26'h0;
   endproperty
   a_stat: assert property (p_stat) else $error("state high bits set");

   c_unlock: cover property (r_reg.st == ST_SECOND ##[1:20] r_reg.st == ST_ACTIVE);
   c_perase: cover property (r_reg.st == ST_PERASE ##1 r_reg.st == ST_PERASE);
   c_prog: cover property (r_reg.core_done);
   c_sect: cover property (r_reg.st == ST_SECTSEL ##[1:20] r_reg.sector_lock != 8'h00);
endmodule
`default_nettype wire

// ---- hw/fpe_pkg.sv ----
/*
 * Shared constants and types of the flash program/erase sequencer.
 * Assumes a 200 MHz pclk and a 32-bit APB master reaching the registers.
 */
`default_nettype none
package fpe_pkg;
   // ***********************************
   // Register map (index, byte address = 4 * index)
   // ***********************************
   localparam logic [11:0] IDX_CMD = 12'hff8;
   localparam logic [11:0] IDX_PAGE = 12'hff9;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam int PAGE_LSB = 9;
   localparam int INFO_EN_BIT = 7;

   // ***********************************
   // Command codes and state codes
   // ***********************************
   localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
   localparam logic [7:0] CMD_UNLOCK2 = 8'h8c;
   localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
   localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
   localparam logic [7:0] CMD_SECT_ACCESS = 8'h5e;
   localparam logic [5:0] STAT_LOCKED = 6'h00;
   localparam logic [5:0] STAT_FIRST = 6'h01;
   localparam logic [5:0] STAT_SECOND = 6'h02;
   localparam logic [5:0] STAT_UNLOCKED = 6'h03;
   localparam logic [5:0] STAT_SECTSEL = 6'h04;
   localparam logic [2:0] STAT_PROG = 3'h1;
   localparam logic [2:0] STAT_PERASE = 3'h2;
   localparam logic [2:0] STAT_MERASE = 3'h4;

   // ***********************************
   // Timing
   // ***********************************
   localparam int CLK_PERIOD_PS = 5000;
   localparam int PROG_TIME_NS = 40000;
   localparam int PERASE_TIME_US = 10000;
   localparam int MERASE_TIME_US = 200000;
   localparam int PROG_CYCLES = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PERASE_CYCLES = (PERASE_TIME_US * 1000 + CLK_PERIOD_PS / 1000 - 1)
                                  / (CLK_PERIOD_PS / 1000);
   localparam int MERASE_CYCLES = (MERASE_TIME_US * 1000 + CLK_PERIOD_PS / 1000 - 1)
                                  / (CLK_PERIOD_PS / 1000);

   typedef enum logic [3:0] {
      ST_LOCKED = 4'b0000,
      ST_FIRST = 4'b0001,
      ST_SECOND = 4'b0010,
      ST_ACTIVE = 4'b0011,
      ST_SECTSEL = 4'b0100,
      ST_PROG = 4'b0101,
      ST_PERASE = 4'b0110,
      ST_MERASE = 4'b0111
   } fpe_state_t;

   typedef struct packed {
      logic valid;
      logic dbg;
      logic [15:0] addr;
      logic [7:0] data;
   } fpe_core_req_t;

   typedef struct packed {
      logic re;
      logic we;
      logic page_erase;
      logic mass_erase;
      logic [15:0] addr;
      logic [7:0] wdata;
   } fpe_flash_t;
endpackage
`default_nettype wire

// ---- hw/fpe_op_timer.sv ----
/*
 * Down counter that times one program or erase pulse.
 * Assumes start is a one-cycle pulse and load is at least one.
 */
`default_nettype none
module fpe_op_timer
   import fpe_pkg::*;
#(
   parameter int WIDTH = 32
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [WIDTH-1:0] load,
   output logic done
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [WIDTH-1:0] cnt;
   } fpe_tmr_t;

   fpe_tmr_t r_reg, r_next;

   initial begin
      if (WIDTH < 2 || WIDTH > 32) begin
         $error("fpe_op_timer: WIDTH out of range");
      end
   end

   always_comb begin
      r_next = r_reg;
      r_next.done = 1'b0;
      if (start) begin
         r_next.busy = 1'b1;
         r_next.cnt = load;
      end else if (r_reg.busy) begin
         if (r_reg.cnt <= WIDTH'(1)) begin
            r_next.busy = 1'b0;
            r_next.done = 1'b1;
         end else begin
            r_next.cnt = r_reg.cnt - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign done = r_reg.done;
endmodule
`default_nettype wire

// ---- tb/fpe_flash_model.sv ----
/*
 * Behavioural flash array on the sequencer's fl port.
 * Assumes fl strobes are one-cycle pulses on pclk.
 */
`default_nettype none
module fpe_flash_model
   import fpe_pkg::*;
(
   input wire logic pclk,
   input wire fpe_flash_t fl,
   output logic [7:0] fl_rdata
);
   logic [7:0] mem [int];

   function automatic logic [7:0] peek(input int a);
      return mem.exists(a) ? mem[a] : ERASED_BYTE;
   endfunction

   initial fl_rdata = 8'h00;

   // Stores wdata as given, so a missing AND in the sequencer shows up
   always @(posedge pclk) begin
      if (fl.re) begin
         fl_rdata <= peek(int'(fl.addr));
      end else begin
         // Toggle outside an answer so stale data is never trusted
         fl_rdata <= ~fl_rdata;
      end
      if (fl.we) begin
         mem[int'(fl.addr)] = fl.wdata;
      end
      if (fl.page_erase) begin
         for (int i = 0; i < 512; i++) begin
            mem.delete(int'({fl.addr[15:9], 9'h000}) + i);
         end
      end
      if (fl.mass_erase) begin
         mem.delete();
      end
   end
endmodule
`default_nettype wire

// ---- tb/flash_program_erase_controller_tb.sv ----
/*
 * Self-checking bench of the flash program/erase sequencer.
 * Assumes shortened operation counts and the behavioural flash model.
 */
`default_nettype none
module flash_program_erase_controller_tb import fpe_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] A_CMD = 16'h3fe0;
   localparam logic [15:0] A_PAGE = 16'h3fe4;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, refd, st;
   logic debug_access, write_protect_option, core_done, core_refused, cpu_stall, info_map_en;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [7:0] fl_rdata, b;
   fpe_core_req_t core_req;
   fpe_flash_t fl;
   int miscompares, tests_run;

   fpe_controller #(.PROG_CYC(4), .PERASE_CYC(20), .MERASE_CYC(30)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .debug_access(debug_access), .write_protect_option(write_protect_option),
      .core_req(core_req), .core_done(core_done), .core_refused(core_refused),
      .cpu_stall(cpu_stall), .info_map_en(info_map_en), .fl(fl), .fl_rdata(fl_rdata));
   fpe_flash_model u_flash (.pclk(pclk), .fl(fl), .fl_rdata(fl_rdata));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // ***********************************
   // Bench tasks
   // ***********************************
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
      return seed[7:0];
   endfunction

   function automatic logic [7:0] bad_cmd();
      logic [7:0] c;
      c = rnd();
      while (c inside {CMD_UNLOCK1, CMD_UNLOCK2, CMD_PAGE_ERASE, CMD_MASS_ERASE,
                       CMD_SECT_ACCESS}) c = rnd();
      return c;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Entered just after a rising edge; leaves one idle cycle after release
   task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
      logic [7:0] j;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {rnd(), rnd(), rnd(), d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle bus carries junk, so decode must lean on psel alone
      j = rnd();
      pwrite <= j[0];
      paddr <= {rnd(), rnd()};
      pwdata <= {rnd(), rnd(), rnd(), rnd()};
      @(posedge pclk);
   endtask

   task automatic cmd(input logic [7:0] d);
      apb(1'b1, A_CMD, d);
   endtask

   task automatic unlock(input logic [7:0] p);
      cmd(8'h00);
      apb(1'b1, A_PAGE, p);
      cmd(CMD_UNLOCK1);
      cmd(CMD_UNLOCK2);
      if (debug_access !== 1'b1) apb(1'b1, A_PAGE, p);
   endtask

   task automatic prog(input logic [15:0] a, input logic [7:0] d);
      st = 1'b0;
      core_req <= '{1'b1, debug_access, a, d};
      do begin
         @(posedge pclk);
         st = st | cpu_stall;
      end while (core_done !== 1'b1 && core_refused !== 1'b1);
      refd = core_refused;
      core_req.valid <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wait_idle();
      do apb(1'b0, A_CMD, 8'h00); while (rd[5:3] !== 3'b000);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ***********************************
   // Scenarios
   // ***********************************
   initial begin
      {presetn, psel, penable, pwrite, debug_access} = '0;
      paddr = '0;
      pwdata = '0;
      write_protect_option = 1'b1;
      core_req = '0;
      seed = 32'd89805;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, A_CMD, 8'h00); check(rd, 32'h0);
      apb(1'b0, 16'h0100, 8'h00); check(32'(err), 32'h1);
      apb(1'b1, A_PAGE, 8'h80); check(32'(info_map_en), 32'h1);
      $display("test reset_and_map done");
      unlock(8'h01);
      apb(1'b0, A_CMD, 8'h00); check(rd, {26'h0, STAT_UNLOCKED});
      b = rnd();
      prog(16'h0234, b); check(32'(refd), 32'h0);
      check(32'(st), 32'h1);
      prog(16'h0234, 8'hf0); check(32'(u_flash.peek(32'h0234)), 32'(b & 8'hf0));
      prog(16'h0434, 8'h00); check(32'(refd), 32'h1);
      cmd(CMD_PAGE_ERASE);
      apb(1'b0, A_CMD, 8'h00); check(32'(rd[7:3]), {27'h0, STAT_PERASE});
      check(32'(cpu_stall), 32'h1);
      wait_idle(); check(rd, 32'h0);
      check(32'(cpu_stall), 32'h0);
      check(32'(u_flash.peek(32'h0234)), 32'hff);
      $display("test program_and_page_erase done");
      repeat (4) begin
         unlock(8'h01);
         cmd(bad_cmd());
         apb(1'b0, A_CMD, 8'h00); check(rd, 32'h0);
         cmd(CMD_UNLOCK1);
         cmd(bad_cmd());
         apb(1'b0, A_CMD, 8'h00); check(rd, 32'h0);
      end
      cmd(CMD_UNLOCK2);
      apb(1'b0, A_CMD, 8'h00); check(rd, 32'h0);
      $display("test relock done");
      unlock(8'h00);
      prog(16'h0010, 8'h3c);
      cmd(8'h00);
      cmd(CMD_UNLOCK1);
      cmd(CMD_SECT_ACCESS);
      apb(1'b0, A_CMD, 8'h00); check(rd, {26'h0, STAT_SECTSEL});
      apb(1'b1, A_PAGE, 8'h01);
      cmd(CMD_UNLOCK1);
      cmd(CMD_SECT_ACCESS);
      apb(1'b0, A_PAGE, 8'h00); check(rd, 32'h1);
      apb(1'b1, A_PAGE, 8'h00);
      cmd(CMD_UNLOCK1);
      cmd(CMD_SECT_ACCESS);
      apb(1'b0, A_PAGE, 8'h00); check(rd, 32'h1);
      cmd(8'h00);
      apb(1'b0, A_PAGE, 8'h00); check(rd, 32'h0);
      unlock(8'h00);
      prog(16'h0020, 8'h11); check(32'(refd), 32'h1);
      cmd(CMD_PAGE_ERASE);
      repeat (30) @(posedge pclk);
      check(32'(u_flash.peek(32'h0010)), 32'h3c);
      $display("test sector_lock done");
      // Write protect off: the core is refused, the debugger below is not
      write_protect_option <= 1'b0;
      unlock(8'h01);
      prog(16'h0200, 8'h00); check(32'(refd), 32'h1);
      cmd(CMD_PAGE_ERASE);
      apb(1'b0, A_CMD, 8'h00); check(rd, 32'h0);
      debug_access <= 1'b1;
      unlock(8'h00);
      apb(1'b0, A_CMD, 8'h00); check(rd, {26'h0, STAT_UNLOCKED});
      cmd(CMD_MASS_ERASE);
      apb(1'b0, A_CMD, 8'h00); check(32'(rd[7:3]), {27'h0, STAT_MERASE});
      wait_idle(); check(rd, 32'h0);
      check(32'(u_flash.peek(32'h0010)), 32'hff);
      b = rnd();
      prog(16'h1234, b); check(32'(u_flash.peek(32'h1234)), 32'(b));
      prog(16'h0010, 8'h5a); check(32'(refd), 32'h0);
      debug_access <= 1'b0;
      $display("test debug_mass_erase done");
      tally_and_finish();
   end

   // Whole run takes several hundred cycles
   initial begin
      #(20000 * 5);
      miscompares++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
